// ---- verilog/swd_top.sv ----
// Decode, check and execute of privileged and ancillary register writes
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module swd_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              instr_valid,
	output logic                   instr_ready,
	input  wire logic [31:0]       instr,
	input  wire logic [63:0]       rs1_val,
	input  wire logic [63:0]       rs2_val,
	output logic                   done,
	output swd_pkg::swd_exc_t      exc,
	output swd_pkg::swd_wr_t       wr,
	output logic                   sir_req,
	output logic      [2:0]        trap_level_reg,
	output logic      [11:0]       pstate
);
	////////////////////////////////////////////////////////////////////////////
	// Architectural state held here
	logic [7:0]        fp_reg_status;
	logic [63:0]       perf_control_reg;
	logic [63:0]       instr_prefix_reg;
	logic [63:0]       trap_prefix_reg;
	logic [31:0]       exc_count;
	swd_pkg::swd_exc_e_t last_code;
	logic              ctrl_enable;
	logic [2:0]        trap_sel;
	logic [63:0]       sel_tpc;
	logic [8:0]        sel_tt;

	////////////////////////////////////////////////////////////////////////////
	// Instruction fields
	wire [1:0]  f_op   = instr[31:30];
	wire [4:0]  f_rd   = instr[29:25];
	wire [5:0]  f_op3  = instr[24:19];
	wire [4:0]  f_rs1  = instr[18:14];
	wire        f_imm  = instr[13];
	wire [12:0] f_simm = instr[12:0];

	// Instruction classes
	wire is_arith = (f_op == swd_pkg::OP_ARITH);
	wire is_wrpr  = is_arith && (f_op3 == swd_pkg::OP3_WRPR);
	wire is_ancillary_reg_write_instr = is_arith && (f_op3 == swd_pkg::OP3_ANCILLARY_REG_WRITE_INSTR);
	wire is_bar   = is_arith && (f_op3 == swd_pkg::OP3_RDASR) &&
		(f_rs1 == swd_pkg::BARRIER_RS1) && (f_rd == 5'h00);
	wire is_write = is_wrpr || is_ancillary_reg_write_instr;

	// Exclusive-or operand
	wire [63:0] op2   = f_imm ? {{51{f_simm[12]}}, f_simm} : rs2_val;
	wire [63:0] wdata = rs1_val ^ op2;

	////////////////////////////////////////////////////////////////////////////
	// Current prefix slot: first slot if valid, else second
	swd_pkg::swd_slot_t slot_f;
	swd_pkg::swd_slot_t slot_s;
	swd_pkg::swd_slot_t slot_c;
	assign slot_f = instr_prefix_reg[swd_pkg::XAR_F_LSB +: 14];
	assign slot_s = instr_prefix_reg[swd_pkg::XAR_S_LSB +: 14];
	assign slot_c = slot_f.v ? slot_f : slot_s;

	// Extension misuse on a write instruction
	wire pfx_misuse = slot_c.v && (slot_c.simd || (slot_c.src1_reg_extension > 3'h1) ||
		(!f_imm && (slot_c.src2_reg_extension > 3'h1)) || (f_imm && (slot_c.src2_reg_extension != 3'h0)) ||
		(slot_c.src3_reg_extension != 3'h0) || (slot_c.urd != 3'h0));

	////////////////////////////////////////////////////////////////////////////
	// Privilege and enables
	wire user     = !pstate[swd_pkg::PST_SUPERVISOR_BIT];
	wire pcr_lock = perf_control_reg[swd_pkg::PCR_SUPERVISOR_BIT];
	wire fp_on    = pstate[swd_pkg::PST_PEF] && fp_reg_status[swd_pkg::FP_REG_STATUS_FEF];
	wire tl_zero  = (trap_level_reg == 3'h0);

	// Privileged write checks
	wire pr_rsv   = is_wrpr && (f_rd > swd_pkg::PR_LAST);
	wire pr_tl0   = is_wrpr && swd_pkg::swd_is_trap_copy(f_rd) && tl_zero;
	wire [2:0] gsel = {wdata[swd_pkg::PST_AG], wdata[swd_pkg::PST_IG],
		wdata[swd_pkg::PST_MG]};
	wire pr_glob  = is_wrpr && (f_rd == swd_pkg::PR_PSTATE) &&
		(gsel != 3'h0) && ((gsel & (gsel - 3'h1)) != 3'h0);

	// Ancillary write checks
	wire rd_sir   = is_ancillary_reg_write_instr && (f_rd == swd_pkg::ASR_SIR);
	wire sir_ok   = rd_sir && (f_rs1 == 5'h00) && f_imm;
	wire asr_rsv  = is_ancillary_reg_write_instr && swd_pkg::swd_asr_reserved(f_rd);
	wire sir_bad  = rd_sir && !sir_ok;
	wire rd_pfx   = is_ancillary_reg_write_instr && ((f_rd == swd_pkg::ASR_XAR) ||
		(f_rd == swd_pkg::ASR_TRAP_PREFIX_REG));
	wire trap_prefix_reg_tl0 = is_ancillary_reg_write_instr && (f_rd == swd_pkg::ASR_TRAP_PREFIX_REG) && tl_zero;
	wire pfx_rsv  = rd_pfx && ((wdata & swd_pkg::XAR_RSV_MASK) != 64'h0);
	wire sup_only = is_ancillary_reg_write_instr && (((f_rd >= swd_pkg::ASR_DCR) &&
		(f_rd != swd_pkg::ASR_GSR) && (f_rd <= swd_pkg::ASR_STCMP)) ||
		(f_rd == swd_pkg::ASR_TRAP_PREFIX_REG));
	wire rd_perf  = is_ancillary_reg_write_instr && ((f_rd == swd_pkg::ASR_PCR) ||
		(f_rd == swd_pkg::ASR_PIC));
	wire perf_act = user && rd_perf && (pcr_lock || ((f_rd == swd_pkg::ASR_PCR) &&
		(wdata[swd_pkg::PCR_SUPERVISOR_BIT] != pcr_lock)));
	wire gsr_off  = is_ancillary_reg_write_instr && (f_rd == swd_pkg::ASR_GSR) && !fp_on;

	////////////////////////////////////////////////////////////////////////////
	// Fixed priority: decode illegal, privilege, fp, action, field illegal, perf action
	wire e_ill_hi = pr_rsv || pr_tl0 || asr_rsv || sir_bad || trap_prefix_reg_tl0;
	wire e_popc   = (is_wrpr && user) || (sup_only && user);
	wire e_fpd    = gsr_off;
	wire e_act    = (is_write && pfx_misuse) || (is_bar && slot_c.v);
	wire e_ill_lo = pr_glob || pfx_rsv;
	wire e_pact   = perf_act;

	swd_pkg::swd_exc_e_t next_code;
	assign next_code = e_ill_hi ? swd_pkg::SWD_EXC_ILL_INSTR  :
		e_popc   ? swd_pkg::SWD_EXC_SUPERVISOR_BIT_OPC   :
		e_fpd    ? swd_pkg::SWD_EXC_FP_DIS     :
		e_act    ? swd_pkg::SWD_EXC_ILL_ACTION :
		e_ill_lo ? swd_pkg::SWD_EXC_ILL_INSTR  :
		e_pact   ? swd_pkg::SWD_EXC_SUPERVISOR_BIT_ACT   :
		swd_pkg::SWD_EXC_NONE;

	////////////////////////////////////////////////////////////////////////////
	// Commit qualifiers; no wait states, so the next op sees new state
	assign instr_ready = ctrl_enable;
	wire take   = instr_valid && instr_ready;
	wire clean  = take && (next_code == swd_pkg::SWD_EXC_NONE);
	wire do_pr  = clean && is_wrpr;
	wire do_asr = clean && is_ancillary_reg_write_instr && !sir_ok;
	wire stk_we = do_pr && swd_pkg::swd_is_trap_copy(f_rd);

	// Trap level write clamps to the deepest copy
	wire [2:0] next_tl = (wdata > 64'(swd_pkg::MAX_TL)) ? swd_pkg::MAX_TL : wdata[2:0];

	// Prefix image with empty slots forced to zero
	function automatic logic [63:0] swd_pfx_clean(input logic [63:0] v);
		logic [63:0] r;
		r = v;
		if (!v[swd_pkg::XAR_F_LSB + 13])
			r[swd_pkg::XAR_F_LSB +: 14] = 14'h0000;
		if (!v[swd_pkg::XAR_S_LSB + 13])
			r[swd_pkg::XAR_S_LSB +: 14] = 14'h0000;
		return r;
	endfunction

	// The current prefix slot is spent by any other instruction taken without an exception
	wire [63:0] spent_pfx = slot_f.v ?
		{instr_prefix_reg[63:32], 14'h0000, instr_prefix_reg[17:0]} :
		{instr_prefix_reg[63:18], 14'h0000, instr_prefix_reg[3:0]};

	////////////////////////////////////////////////////////////////////////////
	// Per-level trap copies
	swd_trap_stack u_stack (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (stk_we),
		.wr_level (trap_level_reg),
		.wr_field (f_rd[1:0]),
		.wr_data  (wdata),
		.rd_level (trap_sel),
		.rd_tpc   (sel_tpc),
		.rd_tt    (sel_tt)
	);

	// Software view
	swd_apb u_apb (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.status      ({20'h0, pstate[3:0], 1'b0, last_code, 1'b0, trap_level_reg}),
		.exc_count   (exc_count),
		.sel_tpc     (sel_tpc),
		.sel_tt      (sel_tt),
		.ctrl_enable (ctrl_enable),
		.trap_sel    (trap_sel)
	);

	////////////////////////////////////////////////////////////////////////////
	// Trap level and processor state, written in the accept cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trap_level_reg <= 3'h0;
			pstate         <= swd_pkg::PSTATE_RESET;
		end
		else if (do_pr)
		begin
			if (f_rd == swd_pkg::PR_TL)
				trap_level_reg <= next_tl;
			if (f_rd == swd_pkg::PR_PSTATE)
				pstate <= (pstate & ~swd_pkg::PSTATE_WMASK) |
					(wdata[11:0] & swd_pkg::PSTATE_WMASK);
		end
	end

	// Ancillary registers; FP status and PCR steer the checks above
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fp_reg_status    <= 8'h00;
			perf_control_reg <= 64'h0;
			trap_prefix_reg  <= 64'h0;
		end
		else if (do_asr)
		begin
			case (f_rd)
				swd_pkg::ASR_FP_REG_STATUS: fp_reg_status    <= wdata[7:0];
				swd_pkg::ASR_PCR:  perf_control_reg <= wdata;
				swd_pkg::ASR_TRAP_PREFIX_REG: trap_prefix_reg  <= swd_pfx_clean(wdata);
				default:           fp_reg_status    <= fp_reg_status;
			endcase
		end
	end

	// Prefix register: written, or its current slot consumed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr_prefix_reg <= 64'h0;
		else if (do_asr && (f_rd == swd_pkg::ASR_XAR))
			instr_prefix_reg <= swd_pfx_clean(wdata);
		else if (clean)
			instr_prefix_reg <= spent_pfx;
	end

	////////////////////////////////////////////////////////////////////////////
	// Result port; targets kept elsewhere are handed out on wr
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done      <= 1'b0;
			exc       <= '0;
			wr        <= '0;
			sir_req   <= 1'b0;
		end
		else
		begin
			done      <= take;
			exc.valid <= take && (next_code != swd_pkg::SWD_EXC_NONE);
			exc.code  <= take ? next_code : swd_pkg::SWD_EXC_NONE;
			wr.valid  <= do_pr || do_asr; // Barrier never writes
			wr.is_pr  <= is_wrpr;
			wr.rd     <= f_rd;
			wr.data   <= wdata;
			sir_req   <= clean && sir_ok;
		end
	end

	// Software-visible record of faults
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			exc_count <= 32'h0;
			last_code <= swd_pkg::SWD_EXC_NONE;
		end
		else if (take && (next_code != swd_pkg::SWD_EXC_NONE))
		begin
			exc_count <= exc_count + 32'h1;
			last_code <= next_code;
		end
	end
endmodule

// ---- verilog/swd_pkg.sv ----
// Constants, types and decode helpers for the state register write decoder
package swd_pkg;
	// Instruction fields
	localparam logic [1:0] OP_ARITH    = 2'h2;
	localparam logic [5:0] OP3_ANCILLARY_REG_WRITE_INSTR   = 6'h30;
	localparam logic [5:0] OP3_WRPR    = 6'h32;
	localparam logic [5:0] OP3_RDASR   = 6'h28;
	localparam logic [4:0] BARRIER_RS1 = 5'h0F;
	// Privileged register targets
	localparam logic [4:0] PR_TPC    = 5'h00;
	localparam logic [4:0] PR_TNPC   = 5'h01;
	localparam logic [4:0] PR_TSTATE = 5'h02;
	localparam logic [4:0] PR_TT     = 5'h03;
	localparam logic [4:0] PR_PSTATE = 5'h06;
	localparam logic [4:0] PR_TL     = 5'h07;
	localparam logic [4:0] PR_LAST   = 5'h0E;
	// Ancillary register targets
	localparam logic [4:0] ASR_FP_REG_STATUS  = 5'h06;
	localparam logic [4:0] ASR_SIR   = 5'h0F;
	localparam logic [4:0] ASR_PCR   = 5'h10;
	localparam logic [4:0] ASR_PIC   = 5'h11;
	localparam logic [4:0] ASR_DCR   = 5'h12;
	localparam logic [4:0] ASR_GSR   = 5'h13;
	localparam logic [4:0] ASR_STCMP = 5'h19;
	localparam logic [4:0] ASR_XAR   = 5'h1D;
	localparam logic [4:0] ASR_TRAP_PREFIX_REG  = 5'h1F;
	// Trap levels and state field positions
	localparam int         NUM_TL         = 4;
	localparam logic [2:0] MAX_TL         = 3'h4;
	localparam int         PST_AG         = 0;
	localparam int         PST_SUPERVISOR_BIT       = 2;
	localparam int         PST_PEF        = 4;
	localparam int         PST_MG         = 10;
	localparam int         PST_IG         = 11;
	localparam logic [11:0] PSTATE_WMASK  = 12'hFFF;
	localparam logic [11:0] PSTATE_RESET  = 12'h024;
	localparam int         FP_REG_STATUS_FEF       = 2;
	localparam int         PCR_SUPERVISOR_BIT       = 0;
	localparam logic [8:0] TT_WMASK       = 9'h1FF;
	// Prefix register layout, first slot above second
	localparam int         XAR_F_LSB      = 18;
	localparam int         XAR_S_LSB      = 4;
	localparam logic [63:0] XAR_RSV_MASK  = 64'hFFFFFFFF0000000F;
	// Register bus map
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_EXCCNT = 8'h08;
	localparam logic [7:0] A_TSEL   = 8'h0C;
	localparam logic [7:0] A_TPC    = 8'h10;
	localparam logic [7:0] A_TT     = 8'h14;
	localparam logic       CTRL_RESET = 1'h1;

	typedef enum logic [2:0] {
		SWD_EXC_NONE       = 3'h0,
		SWD_EXC_ILL_INSTR  = 3'h1,
		SWD_EXC_SUPERVISOR_BIT_OPC   = 3'h2,
		SWD_EXC_FP_DIS     = 3'h3,
		SWD_EXC_ILL_ACTION = 3'h4,
		SWD_EXC_SUPERVISOR_BIT_ACT   = 3'h5
	} swd_exc_e_t;

	typedef struct packed {
		logic       v;
		logic       simd;
		logic [2:0] src1_reg_extension;
		logic [2:0] src2_reg_extension;
		logic [2:0] src3_reg_extension;
		logic [2:0] urd;
	} swd_slot_t;

	typedef struct packed {
		logic       valid;
		swd_exc_e_t code;
	} swd_exc_t;

	typedef struct packed {
		logic        valid;
		logic        is_pr;
		logic [4:0]  rd;
		logic [63:0] data;
	} swd_wr_t;

	// Ancillary targets that do not exist
	function automatic logic swd_asr_reserved(input logic [4:0] rd);
		return (rd == 5'h01) || (rd == 5'h04) || (rd == 5'h05) ||
			(rd >= 5'h07 && rd <= 5'h0E) || (rd >= 5'h1A && rd <= 5'h1C);
	endfunction

	// Per-level trap copies
	function automatic logic swd_is_trap_copy(input logic [4:0] rd);
		return rd <= PR_TT;
	endfunction
endpackage

// ---- verilog/swd_trap_stack.sv ----
// Per-trap-level copies of trap PC, next PC, state and type
`timescale 1ns/1ns
module swd_trap_stack (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_level,
	input  wire logic [1:0]  wr_field,
	input  wire logic [63:0] wr_data,
	input  wire logic [2:0]  rd_level,
	output logic      [63:0] rd_tpc,
	output logic      [8:0]  rd_tt
);
	logic [63:0] tpc    [swd_pkg::NUM_TL];
	logic [63:0] tnpc   [swd_pkg::NUM_TL];
	logic [63:0] tstate [swd_pkg::NUM_TL];
	logic [8:0]  tt     [swd_pkg::NUM_TL];
	wire  [1:0]  rd_idx = rd_level[1:0] - 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// One copy per level; level 1 lives in slot 0
	genvar g;
	generate
		for (g = 0; g < swd_pkg::NUM_TL; g++)
		begin : gen_lvl
			wire hit = wr_en && (wr_level == 3'(g + 1));
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					tpc[g]    <= 64'h0;
					tnpc[g]   <= 64'h0;
					tstate[g] <= 64'h0;
					tt[g]     <= 9'h000;
				end
				else if (hit)
				begin
					case (wr_field)
						2'h0:    tpc[g]    <= wr_data;
						2'h1:    tnpc[g]   <= wr_data;
						2'h2:    tstate[g] <= wr_data;
						default: tt[g]     <= wr_data[8:0] & swd_pkg::TT_WMASK;
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Readback for software; level 0 has no copy and reads zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_tpc <= 64'h0;
			rd_tt  <= 9'h000;
		end
		else
		begin
			rd_tpc <= (rd_level == 3'h0) ? 64'h0 : tpc[rd_idx];
			rd_tt  <= (rd_level == 3'h0) ? 9'h000 : tt[rd_idx];
		end
	end
endmodule

// ---- verilog/swd_apb.sv ----
// APB slave holding the decoder's control and status words
`timescale 1ns/1ns
module swd_apb (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] status,
	input  wire logic [31:0] exc_count,
	input  wire logic [63:0] sel_tpc,
	input  wire logic [8:0]  sel_tt,
	output logic             ctrl_enable,
	output logic      [2:0]  trap_sel
);
	wire access = psel && penable;
	wire mapped = (paddr <= swd_pkg::A_TT) && (paddr[1:0] == 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// Zero-wait slave; unaligned or unmapped words answer with an error
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	always_comb
	begin
		case (paddr)
			swd_pkg::A_CTRL:   prdata = {31'h0, ctrl_enable};
			swd_pkg::A_STATUS: prdata = status;
			swd_pkg::A_EXCCNT: prdata = exc_count;
			swd_pkg::A_TSEL:   prdata = {29'h0, trap_sel};
			swd_pkg::A_TPC:    prdata = sel_tpc[31:0];
			swd_pkg::A_TT:     prdata = {23'h0, sel_tt};
			default:           prdata = 32'h0;
		endcase
	end

	// Writes land on the access edge only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_enable <= swd_pkg::CTRL_RESET;
			trap_sel    <= 3'h0;
		end
		else if (access && pwrite)
		begin
			if (paddr == swd_pkg::A_CTRL)
				ctrl_enable <= pwdata[0];
			if (paddr == swd_pkg::A_TSEL)
				trap_sel <= pwdata[2:0];
		end
	end
endmodule

// ---- verif/swd_top_sva.sv ----
// Concurrent checks on the ports of the state register write decoder
`timescale 1ns/1ns
module swd_top_sva (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              instr_valid,
	input wire logic              instr_ready,
	input wire logic [31:0]       instr,
	input wire logic [63:0]       rs1_val,
	input wire logic [63:0]       rs2_val,
	input wire logic              done,
	input wire swd_pkg::swd_exc_t exc,
	input wire swd_pkg::swd_wr_t  wr,
	input wire logic              sir_req,
	input wire logic [2:0]        trap_level_reg,
	input wire logic [11:0]       pstate
);
	// Decode of the instruction at its accept edge
	wire       acc    = instr_valid && instr_ready;
	wire       arith  = acc && instr[31:30] == swd_pkg::OP_ARITH;
	wire       is_pr  = arith && instr[24:19] == swd_pkg::OP3_WRPR;
	wire       is_asr = arith && instr[24:19] == swd_pkg::OP3_ANCILLARY_REG_WRITE_INSTR;
	wire [4:0] rd_f   = instr[29:25];
	wire       pr_wr  = wr.valid && wr.is_pr;
	wire       ill    = exc.valid && exc.code == swd_pkg::SWD_EXC_ILL_INSTR;

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Answer timing and exclusivity of outcomes
	a_done_after_accept: assert property (acc |=> done) else $error("no done after accept");
	a_done_has_cause: assert property (done |-> $past(acc)) else $error("done without accept");
	a_exc_blocks_write: assert property (exc.valid |-> done && !wr.valid && !sir_req)
		else $error("write or reset alongside exception");
	// Illegal encodings, one cycle after accept
	a_rsv_pr_illegal: assert property (is_pr && rd_f > swd_pkg::PR_LAST |=> ill)
		else $error("reserved privileged target not illegal");
	a_rsv_asr_illegal: assert property (is_asr && rd_f inside {1, 4, 5, [7:14], [26:28]} |=> ill)
		else $error("reserved ancillary target not illegal");
	a_tl0_copy_illegal: assert property (is_pr && rd_f <= swd_pkg::PR_TT && trap_level_reg == 3'h0
		|=> ill) else $error("trap copy write at level zero not illegal");
	a_sir_form_check: assert property (is_asr && rd_f == swd_pkg::ASR_SIR
		&& (instr[18:14] != 5'h00 || !instr[13]) |=> ill && !sir_req) else $error("bad soft reset form");
	// State changes only through their own write
	a_tl_only_write: assert property (!$stable(trap_level_reg) |-> pr_wr && wr.rd == swd_pkg::PR_TL)
		else $error("trap level changed without its write");
	a_tl_value: assert property (pr_wr && wr.rd == swd_pkg::PR_TL |-> trap_level_reg ==
		(wr.data > 64'h4 ? swd_pkg::MAX_TL : wr.data[2:0])) else $error("trap level value wrong");
	a_pstate_write: assert property (!$stable(pstate) |-> pr_wr && wr.rd == swd_pkg::PR_PSTATE
		&& pstate == wr.data[11:0]) else $error("state word changed wrongly");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind swd_top swd_top_sva swd_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr_ready(instr_ready),
	.instr(instr), .rs1_val(rs1_val), .rs2_val(rs2_val), .done(done), .exc(exc), .wr(wr),
	.sir_req(sir_req), .trap_level_reg(trap_level_reg), .pstate(pstate));

// ---- verif/tb_top.sv ----
// Self-checking bench for the state register write decoder
`timescale 1ns/1ns
module tb_top;
	localparam logic [5:0] WP  = swd_pkg::OP3_WRPR;
	localparam logic [5:0] WA  = swd_pkg::OP3_ANCILLARY_REG_WRITE_INSTR;
	localparam logic [2:0] NO  = swd_pkg::SWD_EXC_NONE;
	localparam logic [2:0] ILL = swd_pkg::SWD_EXC_ILL_INSTR;
	localparam logic [2:0] POP = swd_pkg::SWD_EXC_SUPERVISOR_BIT_OPC;
	localparam logic [2:0] FPD = swd_pkg::SWD_EXC_FP_DIS;
	localparam logic [2:0] IAC = swd_pkg::SWD_EXC_ILL_ACTION;
	localparam logic [2:0] PAC = swd_pkg::SWD_EXC_SUPERVISOR_BIT_ACT;
	logic              pclk        = 1'h0;
	logic              presetn     = 1'h0;
	logic              psel        = 1'h0;
	logic              penable     = 1'h0;
	logic              pwrite      = 1'h0;
	logic [7:0]        paddr       = 8'h00;
	logic [31:0]       pwdata      = 32'h0;
	logic              instr_valid = 1'h0;
	logic [31:0]       instr       = 32'h0;
	logic [63:0]       rs1_val     = 64'h0;
	logic [63:0]       rs2_val     = 64'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              instr_ready;
	logic              done;
	swd_pkg::swd_exc_t exc;
	swd_pkg::swd_wr_t  wr;
	logic              sir_req;
	logic [2:0]        trap_level_reg;
	logic [11:0]       pstate;
	logic [31:0]       rdat;
	logic [4:0]        plist [8] = '{5'h12, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1F};
	int                err_count   = 0;
	int                cmp_count   = 0;

	swd_top swd_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr),
		.rs1_val(rs1_val), .rs2_val(rs2_val), .done(done), .exc(exc), .wr(wr),
		.sir_req(sir_req), .trap_level_reg(trap_level_reg), .pstate(pstate)
	);

	always #20 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////////
	// Comparison and closing
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("Compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Instruction word: op, rd, op3, rs1, i, imm13
	function automatic logic [31:0] enc(input logic [5:0] op3, input logic [4:0] rd,
		input logic [4:0] rs1, input logic i, input logic [12:0] imm);
		return {swd_pkg::OP_ARITH, rd, op3, rs1, i, imm};
	endfunction

	// Outcome of an ancillary write of zero, supervisor, level zero, fp off
	function automatic logic [2:0] asr_exp(input int r);
		if (r inside {1, 4, 5, [7:14], [26:28], 31})
			return ILL;
		return (r == 19) ? FPD : NO;
	endfunction

	// One instruction; the answer stands in the cycle after the accept edge
	task automatic exec(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
		input logic [2:0] code, input logic wv);
		@(posedge pclk);
		instr_valid <= 1'h1;
		instr <= ins;
		rs1_val <= a;
		rs2_val <= b;
		@(posedge pclk);
		instr_valid <= 1'h0;
		@(negedge pclk);
		check("done", done, 1'h1);
		check("exc_code", exc.code, code);
		check("exc_valid", exc.valid, code != NO);
		check("wr_valid", wr.valid, wv);
	endtask

	// Immediate zero form, so the written value is the first operand
	task automatic pr(input logic [4:0] rd, input logic [63:0] a, input logic [2:0] code);
		exec(enc(WP, rd, 5'h00, 1'h1, 13'h0), a, 64'h0, code, code == NO);
	endtask

	task automatic asr(input logic [4:0] rd, input logic [63:0] a, input logic [2:0] code);
		exec(enc(WA, rd, 5'h00, 1'h1, 13'h0), a, 64'h0, code,
			code == NO && rd != swd_pkg::ASR_SIR);
	endtask

	// Register bus transfer: setup, then access until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Sample mid-access, clear of the edge that commits the write
		@(negedge pclk);
		while (pready !== 1'h1 && n < 20)
		begin
			@(negedge pclk);
			n++;
		end
		rdat = prdata;
		check("pslverr", pslverr, err);
		@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20)
			err_count++;
	endtask

	task automatic rst;
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		err_count++;
		end_of_test();
	end

	// Main sequence
	initial
	begin
		rst();
		// Nothing taken while the port is disabled; unmapped place refused
		apb(1'h1, swd_pkg::A_CTRL, 32'h0, 1'h0);
		@(posedge pclk);
		instr_valid <= 1'h1;
		instr <= enc(WP, swd_pkg::PR_TL, 5'h00, 1'h1, 13'h3);
		repeat (3) @(posedge pclk);
		instr_valid <= 1'h0;
		check("ready_off", instr_ready, 1'h0);
		check("refused_tl", trap_level_reg, 3'h0);
		apb(1'h1, swd_pkg::A_CTRL, 32'h1, 1'h0);
		apb(1'h0, 8'h40, 32'h0, 1'h1);
		pr(swd_pkg::PR_TPC, 64'h5, ILL);
		for (int k = 0; k < 32; k++)
		begin
			asr(k[4:0], 64'h0, asr_exp(k));
			check("sir", sir_req, k == 15);
		end
		exec(enc(WA, 5'h0F, 5'h01, 1'h1, 13'h0), 64'h0, 64'h0, ILL, 1'h0);
		exec(enc(WA, 5'h0F, 5'h00, 1'h0, 13'h0), 64'h0, 64'h0, ILL, 1'h0);
		for (int k = 15; k < 32; k++)
			pr(k[4:0], 64'h0, ILL);
		// Exclusive-or of register and sign-extended immediate operands
		exec(enc(WP, 5'h05, 5'h01, 1'h0, 13'h2), 64'hF0F0, 64'h0FF0, NO, 1'h1);
		check("xor_reg", wr.data, 64'hFF00);
		check("wr_rd", wr.rd, 5'h05);
		check("wr_is_pr", wr.is_pr, 1'h1);
		exec(enc(WP, 5'h05, 5'h01, 1'h1, 13'h1000), 64'h1, 64'h0, NO, 1'h1);
		check("xor_imm", wr.data, 64'hFFFFFFFFFFFFF001);
		// Trap level write seen by the very next instruction
		@(posedge pclk);
		instr_valid <= 1'h1;
		instr <= enc(WP, swd_pkg::PR_TL, 5'h00, 1'h1, 13'h1);
		rs1_val <= 64'h0;
		@(posedge pclk);
		instr <= enc(WP, swd_pkg::PR_TPC, 5'h00, 1'h1, 13'h0);
		rs1_val <= 64'h11;
		@(posedge pclk);
		instr_valid <= 1'h0;
		@(negedge pclk);
		check("b2b_exc", exc.valid, 1'h0);
		check("b2b_tl", trap_level_reg, 3'h1);
		pr(swd_pkg::PR_TL, 64'h2, NO);
		check("tl_keeps_pstate", pstate, 12'h024);
		pr(swd_pkg::PR_TPC, 64'h22, NO);
		apb(1'h1, swd_pkg::A_TSEL, 32'h1, 1'h0);
		apb(1'h0, swd_pkg::A_TPC, 32'h0, 1'h0);
		check("tpc_l1", rdat, 32'h11);
		apb(1'h1, swd_pkg::A_TSEL, 32'h2, 1'h0);
		apb(1'h0, swd_pkg::A_TPC, 32'h0, 1'h0);
		check("tpc_l2", rdat, 32'h22);
		apb(1'h0, swd_pkg::A_STATUS, 32'h0, 1'h0);
		check("status_tl", rdat[2:0], 3'h2);
		asr(5'h1F, 64'h0, NO);
		// Floating-point enables gate the graphics write
		pr(swd_pkg::PR_PSTATE, 64'h14, NO);
		check("pstate", pstate, 12'h014);
		asr(swd_pkg::ASR_GSR, 64'h0, FPD);
		asr(swd_pkg::ASR_FP_REG_STATUS, 64'h4, NO);
		asr(swd_pkg::ASR_GSR, 64'h0, NO);
		pr(swd_pkg::PR_PSTATE, 64'h415, ILL);
		check("pstate_kept", pstate, 12'h014);
		asr(swd_pkg::ASR_XAR, 64'h1, ILL);
		exec(enc(6'h28, 5'h00, 5'h0F, 1'h0, 13'h0), 64'h0, 64'h0, NO, 1'h0);
		// Prefix slot: cleared valid, legal extension, then misuse
		asr(swd_pkg::ASR_XAR, 64'h7FFC0000, NO);
		asr(5'h02, 64'h0, NO);
		asr(swd_pkg::ASR_XAR, 64'h88000000, NO);
		asr(5'h02, 64'h0, NO);
		asr(swd_pkg::ASR_XAR, 64'h90000000, NO);
		exec(enc(6'h28, 5'h00, 5'h0F, 1'h0, 13'h0), 64'h0, 64'h0, IAC, 1'h0);
		pr(swd_pkg::PR_PSTATE, 64'h415, IAC);
		asr(swd_pkg::ASR_XAR, 64'h1, IAC);
		asr(5'h02, 64'h0, IAC);
		// User mode with the perf lock set
		rst();
		asr(swd_pkg::ASR_PCR, 64'h1, NO);
		pr(swd_pkg::PR_PSTATE, 64'h0, NO);
		asr(swd_pkg::ASR_PIC, 64'h0, PAC);
		asr(swd_pkg::ASR_PCR, 64'h1, PAC);
		// User mode with the perf lock clear
		rst();
		asr(swd_pkg::ASR_PCR, 64'h0, NO);
		pr(swd_pkg::PR_TL, 64'h1, NO);
		pr(swd_pkg::PR_PSTATE, 64'h0, NO);
		asr(swd_pkg::ASR_PCR, 64'h0, NO);
		asr(swd_pkg::ASR_PCR, 64'h1, PAC);
		foreach (plist[j])
			asr(plist[j], 64'h0, POP);
		end_of_test();
	end
endmodule
